// ===== dcr_delay_ctrl_regs.sv
// Register group for the sample-phase delay controller and clock receiver
//
// Summary of operation
// - Duty-cycle register bit 7 turns duty-cycle correction on or off.
// - Duty register bit 6 and bits 5:0 are factory only; no function.
// - Receiver register A bits 7:4 trim negative clock input common mode.
// - Receiver enable resets to zero; one enables, zero disables receiver.
// - Receiver register B bit 5 selects positive trim sign; zero negative.
// - Receiver register B bits 4:1 trim positive clock input common mode.
// - Receiver register B bit 0 selects negative trim sign; zero negative.
// - Control bit 7 gates controller clock; one stops it.
// - Control bit 6 sets desired slope compared at target phase.
// - Mode field: search-track, track only, search only; 11 invalid.
// - Sample bit rising edge captures locked delay and phase.
// - Gain field: slowest, nominal, fastest; 11 invalid.
// - Control bit 0 enables controller; zero means manual mode.
// - Delay value is nine bits yet never exceeds 431.
// - Target phase above 16 never locks.
`timescale 1ns/1ps
module dcr_delay_ctrl_regs
(
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration port from the serial engine, same clock
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  output logic [7:0] cfgRdData,
  output logic cfgRdValid,
  // Duty-cycle and factory fields
  output logic dutyCorrEnable,
  output logic factoryStepDir,
  output logic [5:0] factoryDutyTrim,
  // Clock receiver controls
  output logic [3:0] negClockCmTrim,
  output logic [3:0] posClockCmTrim,
  output logic posTrimSign,
  output logic negTrimSign,
  output logic clockRxEnable,
  output logic clockRxFactory,
  // Delay controller controls
  output logic delayCtrlClockGate,
  output logic desiredSlopePositive,
  output logic searchEnable,
  output logic trackEnable,
  output logic modeInvalid,
  output logic [1:0] trackGain,
  output logic gainInvalid,
  output logic delayCtrlEnable,
  output logic delayCtrlRun,
  // Lock readback capture
  input wire logic [8:0] lockedDelay,
  input wire logic [4:0] lockedPhase,
  output logic [8:0] capturedDelay,
  output logic [4:0] capturedPhase,
  output logic lockReadbackCapture,
  output logic phaseOverRange
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dutyCycle;
    logic [7:0] rxTrimA;
    logic [7:0] rxTrimB;
    logic [7:0] delayCtrl;
    logic [7:0] rdData;
    logic rdValid;
  } dcr_state_type;

  dcr_state_type state_q;
  dcr_state_type state_d;

  logic hitDuty;
  logic hitTrimA;
  logic hitTrimB;
  logic hitCtrl;

  // Address decode
  assign hitDuty = (cfgAddr == dcr_pkg::ADDR_DUTY_CYCLE);
  assign hitTrimA = (cfgAddr == dcr_pkg::ADDR_RX_TRIM_A);
  assign hitTrimB = (cfgAddr == dcr_pkg::ADDR_RX_TRIM_B);
  assign hitCtrl = (cfgAddr == dcr_pkg::ADDR_DELAY_CTRL);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Whole-byte writes keep multi-bit fields from tearing mid-update
  always_comb
  begin
    state_d = state_q;
    state_d.rdValid = 1'b0;
    if (cfgWrEn)
    begin
      if (hitDuty)
        state_d.dutyCycle = cfgWrData;
      if (hitTrimA)
        state_d.rxTrimA = cfgWrData & ~dcr_pkg::RX_TRIM_A_RSVD_MASK;
      if (hitTrimB)
        state_d.rxTrimB = cfgWrData;
      if (hitCtrl)
        state_d.delayCtrl = cfgWrData;
    end
    if (cfgRdEn)
    begin
      state_d.rdValid = 1'b1;
      if (hitDuty)
        state_d.rdData = state_q.dutyCycle;
      else if (hitTrimA)
        state_d.rdData = state_q.rxTrimA;
      else if (hitTrimB)
        state_d.rdData = state_q.rxTrimB;
      else if (hitCtrl)
        state_d.rdData = state_q.delayCtrl;
      else
        state_d.rdData = dcr_pkg::UNMAPPED_READ;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // receiver held disabled from reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q.dutyCycle <= dcr_pkg::RST_DUTY_CYCLE;
      state_q.rxTrimA <= dcr_pkg::RST_RX_TRIM_A;
      state_q.rxTrimB <= dcr_pkg::RST_RX_TRIM_B;
      state_q.delayCtrl <= dcr_pkg::RST_DELAY_CTRL;
      state_q.rdData <= dcr_pkg::UNMAPPED_READ;
      state_q.rdValid <= 1'b0;
    end
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  assign cfgRdData = state_q.rdData;
  assign cfgRdValid = state_q.rdValid;

  assign dutyCorrEnable = state_q.dutyCycle[dcr_pkg::DUTY_EN_BIT];
  // stored, routed only to factory trim
  assign factoryStepDir = state_q.dutyCycle[dcr_pkg::DUTY_EN_BIT-1];
  assign factoryDutyTrim = state_q.dutyCycle[dcr_pkg::DUTY_EN_BIT-2:0];

  assign negClockCmTrim =
    state_q.rxTrimA[dcr_pkg::NEG_TRIM_HI:dcr_pkg::NEG_TRIM_LO];
  assign clockRxEnable = state_q.rxTrimB[dcr_pkg::RX_ENABLE_BIT];
  assign clockRxFactory = state_q.rxTrimB[dcr_pkg::RX_FACTORY_BIT];
  assign posTrimSign = state_q.rxTrimB[dcr_pkg::POS_SIGN_BIT];
  assign posClockCmTrim =
    state_q.rxTrimB[dcr_pkg::POS_TRIM_HI:dcr_pkg::POS_TRIM_LO];
  assign negTrimSign = state_q.rxTrimB[dcr_pkg::NEG_SIGN_BIT];

  assign delayCtrlClockGate = state_q.delayCtrl[dcr_pkg::CLK_GATE_BIT];
  assign desiredSlopePositive = state_q.delayCtrl[dcr_pkg::SLOPE_BIT];
  assign delayCtrlEnable = state_q.delayCtrl[dcr_pkg::CTRL_ENABLE_BIT];
  // Controller runs only when enabled and its clock is not gated
  assign delayCtrlRun = delayCtrlEnable & ~delayCtrlClockGate;

  // ----------------------------------------------------------------
  // Mode and gain decode
  // ----------------------------------------------------------------
  // mode select
  dcr_mode_decode u_decode
  (
    .modeField(state_q.delayCtrl[dcr_pkg::MODE_HI:dcr_pkg::MODE_LO]),
    .gainField(state_q.delayCtrl[dcr_pkg::GAIN_HI:dcr_pkg::GAIN_LO]),
    .searchEnable(searchEnable),
    .trackEnable(trackEnable),
    .modeInvalid(modeInvalid),
    .trackGain(trackGain),
    .gainInvalid(gainInvalid)
  );

  // ----------------------------------------------------------------
  // Lock readback capture
  // ----------------------------------------------------------------
  // capture on sample bit rise
  dcr_lock_capture u_capture
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .captureLevel(state_q.delayCtrl[dcr_pkg::CAPTURE_BIT]),
    .lockedDelay(lockedDelay),
    .lockedPhase(lockedPhase),
    .capturedDelay(capturedDelay),
    .capturedPhase(capturedPhase),
    .capturePulse(lockReadbackCapture),
    .phaseOverRange(phaseOverRange)
  );

endmodule

// ===== dcr_pkg.sv
// Constants and types for the delay controller and clock receiver registers
package dcr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DUTY_CYCLE = 8'h30;
  localparam logic [7:0] ADDR_RX_TRIM_A = 8'h31;
  localparam logic [7:0] ADDR_RX_TRIM_B = 8'h32;
  localparam logic [7:0] ADDR_DELAY_CTRL = 8'h33;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Duty-cycle register
  localparam int DUTY_EN_BIT = 7;
  // Clock receiver register A
  localparam int NEG_TRIM_HI = 7;
  localparam int NEG_TRIM_LO = 4;
  localparam logic [7:0] RX_TRIM_A_RSVD_MASK = 8'h0f;
  // Clock receiver register B
  localparam int RX_ENABLE_BIT = 7;
  localparam int RX_FACTORY_BIT = 6;
  localparam int POS_SIGN_BIT = 5;
  localparam int POS_TRIM_HI = 4;
  localparam int POS_TRIM_LO = 1;
  localparam int NEG_SIGN_BIT = 0;
  // Delay controller control register
  localparam int CLK_GATE_BIT = 7;
  localparam int SLOPE_BIT = 6;
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int CAPTURE_BIT = 3;
  localparam int GAIN_HI = 2;
  localparam int GAIN_LO = 1;
  localparam int CTRL_ENABLE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DUTY_CYCLE = 8'h00;
  localparam logic [7:0] RST_RX_TRIM_A = 8'hf0;
  localparam logic [7:0] RST_RX_TRIM_B = 8'h1e;
  localparam logic [7:0] RST_DELAY_CTRL = 8'h02;

  // ----------------------------------------------------------------
  // Delay line and phase limits
  // ----------------------------------------------------------------
  localparam int DELAY_WIDTH = 9;
  localparam int PHASE_WIDTH = 5;
  localparam logic [8:0] MAX_DELAY = 9'h1af;
  localparam logic [4:0] MAX_PHASE = 5'h10;

  // ----------------------------------------------------------------
  // Operating modes and tracking gains
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SEARCH_TRACK = 2'h0;
  localparam logic [1:0] MODE_TRACK_ONLY = 2'h1;
  localparam logic [1:0] MODE_SEARCH_ONLY = 2'h2;
  localparam logic [1:0] MODE_INVALID = 2'h3;
  localparam logic [1:0] GAIN_SLOW = 2'h0;
  localparam logic [1:0] GAIN_NOMINAL = 2'h1;
  localparam logic [1:0] GAIN_FAST = 2'h2;
  localparam logic [1:0] GAIN_INVALID = 2'h3;

endpackage

// ===== dcr_mode_decode.sv
// Decoder of controller mode and tracking gain fields
`timescale 1ns/1ps
module dcr_mode_decode
(
  input wire logic [1:0] modeField,
  input wire logic [1:0] gainField,
  output logic searchEnable,
  output logic trackEnable,
  output logic modeInvalid,
  output logic [1:0] trackGain,
  output logic gainInvalid
);

  // Mode decode; the invalid code runs neither phase
  always_comb
  begin
    searchEnable = 1'b0;
    trackEnable = 1'b0;
    modeInvalid = 1'b0;
    case (modeField)
      dcr_pkg::MODE_SEARCH_TRACK:
      begin
        searchEnable = 1'b1;
        trackEnable = 1'b1;
      end
      dcr_pkg::MODE_TRACK_ONLY: trackEnable = 1'b1;
      dcr_pkg::MODE_SEARCH_ONLY: searchEnable = 1'b1;
      default: modeInvalid = 1'b1;
    endcase
  end

  // Gain decode; the invalid code falls back to nominal rate
  always_comb
  begin
    trackGain = gainField;
    gainInvalid = 1'b0;
    case (gainField)
      dcr_pkg::GAIN_SLOW,
      dcr_pkg::GAIN_NOMINAL,
      dcr_pkg::GAIN_FAST: trackGain = gainField;
      default:
      begin
        trackGain = dcr_pkg::GAIN_NOMINAL;
        gainInvalid = 1'b1;
      end
    endcase
  end

endmodule

// ===== dcr_lock_capture.sv
// Edge-triggered capture of the locked delay and phase for readback
`timescale 1ns/1ps
module dcr_lock_capture
#(
  parameter int DELAY_W = dcr_pkg::DELAY_WIDTH,
  parameter int PHASE_W = dcr_pkg::PHASE_WIDTH
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic captureLevel,
  input wire logic [DELAY_W-1:0] lockedDelay,
  input wire logic [PHASE_W-1:0] lockedPhase,
  output logic [DELAY_W-1:0] capturedDelay,
  output logic [PHASE_W-1:0] capturedPhase,
  output logic capturePulse,
  output logic phaseOverRange
);

  // Widths must hold the documented limits; refused at elaboration
  if (DELAY_W != dcr_pkg::DELAY_WIDTH || PHASE_W != dcr_pkg::PHASE_WIDTH)
  begin : g_bad_width
    $error("dcr_lock_capture: unsupported field width");
  end

  typedef struct packed {
    logic levelPrev;
    logic pulse;
    logic [DELAY_W-1:0] delay;
    logic [PHASE_W-1:0] phase;
    logic overRange;
  } dcr_cap_type;

  dcr_cap_type cap_q;
  dcr_cap_type cap_d;
  logic rise;

  assign rise = captureLevel & ~cap_q.levelPrev;

  // Next state; only a 0-to-1 change of the level captures
  always_comb
  begin
    cap_d = cap_q;
    cap_d.levelPrev = captureLevel;
    cap_d.pulse = 1'b0;
    if (rise)
    begin
      cap_d.pulse = 1'b1;
      if (lockedDelay > dcr_pkg::MAX_DELAY)
        cap_d.delay = dcr_pkg::MAX_DELAY;
      else
        cap_d.delay = lockedDelay;
      cap_d.phase = lockedPhase;
      cap_d.overRange = (lockedPhase > dcr_pkg::MAX_PHASE);
    end
  end

  // State register; synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cap_q <= '0;
    else
      cap_q <= cap_d;
  end

  assign capturedDelay = cap_q.delay;
  assign capturedPhase = cap_q.phase;
  assign capturePulse = cap_q.pulse;
  assign phaseOverRange = cap_q.overRange;

endmodule

// ===== dcr_delay_ctrl_regs_sva.sv
// Assertions on the delay controller register group ports
`timescale 1ns/1ps
module dcr_regs_chk
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  input wire logic cfgRdValid,
  input wire logic dutyCorrEnable,
  input wire logic [3:0] negClockCmTrim,
  input wire logic [3:0] posClockCmTrim,
  input wire logic posTrimSign,
  input wire logic negTrimSign,
  input wire logic clockRxEnable,
  input wire logic delayCtrlClockGate,
  input wire logic desiredSlopePositive,
  input wire logic searchEnable,
  input wire logic trackEnable,
  input wire logic modeInvalid,
  input wire logic [1:0] trackGain,
  input wire logic gainInvalid,
  input wire logic delayCtrlEnable,
  input wire logic delayCtrlRun,
  input wire logic [8:0] lockedDelay,
  input wire logic [8:0] capturedDelay,
  input wire logic lockReadbackCapture
);
  // ----
  // Write decode and sequences
  // ----
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic w30, w31, w32, w33;
  assign w30 = cfgWrEn && cfgAddr == 8'h30;
  assign w31 = cfgWrEn && cfgAddr == 8'h31;
  assign w32 = cfgWrEn && cfgAddr == 8'h32;
  assign w33 = cfgWrEn && cfgAddr == 8'h33;
  // A capture shows as exactly one cycle
  sequence pulseOnce;
    lockReadbackCapture ##1 !lockReadbackCapture;
  endsequence
  sequence rdAnswer;
    ##1 cfgRdValid;
  endsequence
  rd_answer_a: assert property (cfgRdEn |-> rdAnswer)
    else $error("read not answered");
  duty_write_a: assert property (w30 |=>
    dutyCorrEnable == $past(cfgWrData[7]))
    else $error("duty enable not written");
  neg_trim_a: assert property (w31 |=>
    negClockCmTrim == $past(cfgWrData[7:4]))
    else $error("negative trim not written");
  rx_fields_a: assert property (w32 |=>
    {clockRxEnable, posTrimSign, posClockCmTrim, negTrimSign} ==
    {$past(cfgWrData[7]), $past(cfgWrData[5:0])})
    else $error("receiver fields not written");
  ctrl_bits_a: assert property (w33 |=>
    {delayCtrlClockGate, desiredSlopePositive, delayCtrlEnable} ==
    {$past(cfgWrData[7:6]), $past(cfgWrData[0])})
    else $error("control bits not written");
  // run gating, from the written byte
  run_gate_a: assert property (w33 |=>
    delayCtrlRun == ($past(cfgWrData[0]) && !$past(cfgWrData[7])))
    else $error("run not gated");
  mode_dec_a: assert property (w33 |=>
    {searchEnable, trackEnable, modeInvalid} == {!$past(cfgWrData[4]),
    !$past(cfgWrData[5]), $past(cfgWrData[5:4]) == 2'h3})
    else $error("mode decode wrong");
  gain_dec_a: assert property (w33 |=>
    gainInvalid == ($past(cfgWrData[2:1]) == 2'h3) && trackGain ==
    ($past(cfgWrData[2:1]) == 2'h3 ? 2'h1 : $past(cfgWrData[2:1])))
    else $error("gain decode wrong");
  cap_pulse_a: assert property (lockReadbackCapture |-> pulseOnce)
    else $error("capture pulse too long");
  cap_value_a: assert property (lockReadbackCapture |->
    capturedDelay == ($past(lockedDelay) > 9'h1af ? 9'h1af :
    $past(lockedDelay)))
    else $error("captured delay wrong");
endmodule

bind dcr_delay_ctrl_regs dcr_regs_chk chk_u (.core_clk, .rst_n, .cfgWrEn,
  .cfgRdEn, .cfgAddr, .cfgWrData, .cfgRdValid, .dutyCorrEnable,
  .negClockCmTrim, .posClockCmTrim, .posTrimSign, .negTrimSign,
  .clockRxEnable, .delayCtrlClockGate, .desiredSlopePositive,
  .searchEnable, .trackEnable, .modeInvalid, .trackGain, .gainInvalid,
  .delayCtrlEnable, .delayCtrlRun, .lockedDelay, .capturedDelay,
  .lockReadbackCapture);

// ===== dcr_delay_ctrl_regs_tb_top.sv
// Self-checking bench for the delay controller register group
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("FAIL %s exp %h got %h", n, e, g); \
    end \
  end
module dcr_delay_ctrl_regs_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfgWrEn = 1'b0;
  logic cfgRdEn = 1'b0;
  logic [7:0] cfgAddr = 8'h00;
  logic [7:0] cfgWrData = 8'h00;
  logic [8:0] lockedDelay = 9'h000;
  logic [4:0] lockedPhase = 5'h00;
  logic [7:0] cfgRdData;
  logic [5:0] factoryDutyTrim;
  logic [3:0] negClockCmTrim, posClockCmTrim;
  logic [1:0] trackGain;
  logic [8:0] capturedDelay;
  logic [4:0] capturedPhase;
  logic cfgRdValid, dutyCorrEnable, factoryStepDir, posTrimSign;
  logic negTrimSign, clockRxEnable, clockRxFactory, delayCtrlClockGate;
  logic desiredSlopePositive, searchEnable, trackEnable, modeInvalid;
  logic gainInvalid, delayCtrlEnable, delayCtrlRun;
  logic lockReadbackCapture, phaseOverRange;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  dcr_delay_ctrl_regs dut_u (.core_clk, .rst_n, .cfgWrEn, .cfgRdEn,
    .cfgAddr, .cfgWrData, .cfgRdData, .cfgRdValid, .dutyCorrEnable,
    .factoryStepDir, .factoryDutyTrim, .negClockCmTrim, .posClockCmTrim,
    .posTrimSign, .negTrimSign, .clockRxEnable, .clockRxFactory,
    .delayCtrlClockGate, .desiredSlopePositive, .searchEnable,
    .trackEnable, .modeInvalid, .trackGain, .gainInvalid,
    .delayCtrlEnable, .delayCtrlRun, .lockedDelay, .lockedPhase,
    .capturedDelay, .capturedPhase, .lockReadbackCapture,
    .phaseOverRange);

  // ----
  // Clock, timeout and access tasks
  // ----
  always #10 core_clk = ~core_clk;

  // A run needs under a hundred cycles; far past that it is hung
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    cfgWrEn = 1'b1;
    cfgAddr = a;
    cfgWrData = d;
    @(posedge core_clk) #1;
    cfgWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) #1;
    cfgRdEn = 1'b1;
    cfgAddr = a;
    @(posedge core_clk) #1;
    cfgRdEn = 1'b0;
    `CHK("rdValid", 1'b1, cfgRdValid)
    `CHK("rdData", e, cfgRdData)
  endtask

  // Step to the cycle after a capture would land
  task automatic next();
    @(posedge core_clk) #1;
  endtask

  initial
  begin
    logic [7:0] d;
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1'b1;
    rd(8'h30, 8'h00);
    rd(8'h31, 8'hf0);
    rd(8'h32, 8'h1e);
    rd(8'h33, 8'h02);
    rd(8'h34, 8'h00);
    // duty register fields
    // Factory bits left clear; correction on before the controller
    wr(8'h30, 8'h80);
    `CHK("duty", 8'h80, {dutyCorrEnable, factoryStepDir, factoryDutyTrim})
    wr(8'h34, 8'h00);
    rd(8'h30, 8'h80);
    wr(8'h31, 8'h5a);
    `CHK("negTrim", 4'h5, negClockCmTrim)
    rd(8'h31, 8'h50);
    // receiver fields both ways
    // Bit 6 kept at default; enable only once the clock runs
    for (int i = 0; i < 2; i++)
    begin
      d = i[0] ? 8'h1a : 8'ha5;
      wr(8'h32, d);
      `CHK("rx", d, {clockRxEnable, clockRxFactory, posTrimSign,
        posClockCmTrim, negTrimSign})
      rd(8'h32, d);
    end
    for (int m = 0; m < 4; m++)
    begin
      d = {m[0], m[1], m[1:0], 1'b0, m[1:0], 1'b1};
      wr(8'h33, d);
      `CHK("mode", {~m[0], ~m[1], &m[1:0]},
        {searchEnable, trackEnable, modeInvalid})
      `CHK("gain", {(&m[1:0]) ? 2'h1 : m[1:0], &m[1:0]},
        {trackGain, gainInvalid})
      `CHK("ctl", {m[0], m[1], 1'b1, ~m[0]}, {delayCtrlClockGate,
        desiredSlopePositive, delayCtrlEnable, delayCtrlRun})
      rd(8'h33, d);
    end
    lockedDelay = 9'h0a5;
    lockedPhase = 5'h0e;
    // Positive slope kept set, as software is advised to do
    wr(8'h33, 8'h48);
    `CHK("run", 1'b0, delayCtrlRun)
    next();
    `CHK("cap", {1'b1, 9'h0a5, 5'h0e, 1'b0}, {lockReadbackCapture,
      capturedDelay, capturedPhase, phaseOverRange})
    lockedDelay = 9'h1ff;
    lockedPhase = 5'h11;
    wr(8'h33, 8'h48);
    next();
    `CHK("hold", {1'b0, 9'h0a5}, {lockReadbackCapture,
      capturedDelay})
    wr(8'h33, 8'h40);
    next();
    `CHK("fall", 1'b0, lockReadbackCapture)
    wr(8'h33, 8'h48);
    next();
    `CHK("clamp", {1'b1, 9'h1af, 5'h11, 1'b1}, {lockReadbackCapture,
      capturedDelay, capturedPhase, phaseOverRange})
    // Correction off again once the controller is disabled
    wr(8'h30, 8'h00);
    `CHK("dutyOff", 1'b0, dutyCorrEnable)
    end_sim();
  end
endmodule
